// ### hdl/tim_irq_flags.sv
// Timer with three compare channels, input capture, event flags and interrupt enables.
// Assumes a processor port on the same clock and a capture pin from outside the clock domain.
//
// How it works
// - A capture request is raised only while its enable, the global enable and its flag are set.
// - A channel C request is raised only while its enable, the global enable and its flag are set.
// - A channel B request is raised only while its enable, the global enable and its flag are set.
// - A channel A request is raised only while its enable, the global enable and its flag are set.
// - An overflow request is raised only while its enable, the global enable and its flag are set.
// - Reserved bits of the enable and flag registers read as zero and ignore writes.
// - In modes whose top is not the capture value, a capture event on the capture pin sets the capture flag.
// - In modes whose top is the capture value, reaching that top sets the capture flag.
// - Each compare flag is set in the timer cycle after the counter equals its compare value.
// - Each flag clears when the processor runs the vector that belongs to it.
// - Writing one to a flag bit clears it and writing zero leaves it alone.
// - In normal and clear-on-compare modes the overflow flag is set when the counter overflows.
// - In modes whose top is not the capture value, a capture pin event loads the capture value with the current counter value.
// - Each 16-bit compare value is compared with the running counter on every count tick.
`timescale 1ns/100ps
module tim_irq_flags (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic global_irq_enable_i,
  input wire logic [7:0] vector_ack_i,
  input wire logic count_tick_i,
  input wire logic capture_input_pin_i,
  output logic [7:0] rdata_o,
  output logic [7:0] irq_req_o,
  output logic irq_o
);

  function automatic logic top_is_capture(input logic [3:0] mode);
    return (mode == tim_pkg::MODE_PFC_CAP) || (mode == tim_pkg::MODE_PC_CAP) ||
           (mode == tim_pkg::MODE_CTC_CAP) || (mode == tim_pkg::MODE_FAST_CAP);
  endfunction

  function automatic logic [15:0] top_of(input logic [3:0] mode, input logic [15:0] cmpa,
                                         input logic [15:0] cap);
    case (mode)
      tim_pkg::MODE_PC8, tim_pkg::MODE_FAST8: top_of = tim_pkg::TOP_8BIT;
      tim_pkg::MODE_PC9, tim_pkg::MODE_FAST9: top_of = tim_pkg::TOP_9BIT;
      tim_pkg::MODE_PC10, tim_pkg::MODE_FAST10: top_of = tim_pkg::TOP_10BIT;
      tim_pkg::MODE_CTC_CMPA, tim_pkg::MODE_PFC_CMPA, tim_pkg::MODE_PC_CMPA,
      tim_pkg::MODE_FAST_CMPA: top_of = cmpa;
      tim_pkg::MODE_PFC_CAP, tim_pkg::MODE_PC_CAP, tim_pkg::MODE_CTC_CAP,
      tim_pkg::MODE_FAST_CAP: top_of = cap;
      default: top_of = tim_pkg::CNT_MAX;
    endcase
  endfunction

  function automatic logic overflow_at_max(input logic [3:0] mode);
    return (mode == tim_pkg::MODE_NORMAL) || (mode == tim_pkg::MODE_CTC_CMPA) ||
           (mode == tim_pkg::MODE_CTC_CAP);
  endfunction

  // Capture pin synchroniser; the second and third stages feed the edge detector.
  logic pin_s1_r, pin_s2_r, pin_s3_r;
  logic pin_s1_nxt, pin_s2_nxt, pin_s3_nxt;
  logic pin_rise;

  always_comb begin
    pin_s1_nxt = capture_input_pin_i;
    pin_s2_nxt = pin_s1_r;
    pin_s3_nxt = pin_s2_r;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
      pin_s3_r <= pin_s3_nxt;
    end
  end

  assign pin_rise = pin_s2_r & ~pin_s3_r;

  // Counter, compare and capture state.
  logic [3:0] mode_r, mode_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] cap_r, cap_nxt;
  logic [15:0] cmpa_r, cmpa_nxt;
  logic [15:0] cmpb_r, cmpb_nxt;
  logic [15:0] cmpc_r, cmpc_nxt;
  logic [15:0] top;
  logic at_top, cap_top_mode;
  logic [7:0] set_vec;

  always_comb begin
    mode_nxt = mode_r;
    cap_nxt = cap_r;
    cmpa_nxt = cmpa_r;
    cmpb_nxt = cmpb_r;
    cmpc_nxt = cmpc_r;
    cnt_nxt = cnt_r;
    set_vec = tim_pkg::RESET_BYTE;
    cap_top_mode = top_is_capture(mode_r);
    top = top_of(mode_r, cmpa_r, cap_r);
    at_top = (cnt_r == top);
    if (wr_i) begin
      case (addr_i)
        tim_pkg::ADDR_MODE: mode_nxt = wdata_i[3:0];
        tim_pkg::ADDR_CAP_L: cap_nxt[7:0] = wdata_i;
        tim_pkg::ADDR_CAP_H: cap_nxt[15:8] = wdata_i;
        tim_pkg::ADDR_CMPA_L: cmpa_nxt[7:0] = wdata_i;
        tim_pkg::ADDR_CMPA_H: cmpa_nxt[15:8] = wdata_i;
        tim_pkg::ADDR_CMPB_L: cmpb_nxt[7:0] = wdata_i;
        tim_pkg::ADDR_CMPB_H: cmpb_nxt[15:8] = wdata_i;
        tim_pkg::ADDR_CMPC_L: cmpc_nxt[7:0] = wdata_i;
        tim_pkg::ADDR_CMPC_H: cmpc_nxt[15:8] = wdata_i;
        default: mode_nxt = mode_r;
      endcase
    end
    if (count_tick_i) begin
      cnt_nxt = at_top ? tim_pkg::RESET_WORD : cnt_r + tim_pkg::CNT_STEP;
      set_vec[tim_pkg::BIT_CMPA] = (cnt_r == cmpa_r);
      set_vec[tim_pkg::BIT_CMPB] = (cnt_r == cmpb_r);
      set_vec[tim_pkg::BIT_CMPC] = (cnt_r == cmpc_r);
      set_vec[tim_pkg::BIT_OVF] = overflow_at_max(mode_r) ? (cnt_r == tim_pkg::CNT_MAX) : at_top;
      set_vec[tim_pkg::BIT_CAP] = cap_top_mode & at_top;
    end
    if (pin_rise && !cap_top_mode) begin
      set_vec[tim_pkg::BIT_CAP] = 1'b1;
      cap_nxt = cnt_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= tim_pkg::MODE_NORMAL;
      cnt_r <= tim_pkg::RESET_WORD;
      cap_r <= tim_pkg::RESET_WORD;
      cmpa_r <= tim_pkg::RESET_WORD;
      cmpb_r <= tim_pkg::RESET_WORD;
      cmpc_r <= tim_pkg::RESET_WORD;
    end else begin
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
      cmpa_r <= cmpa_nxt;
      cmpb_r <= cmpb_nxt;
      cmpc_r <= cmpc_nxt;
    end
  end

  // Flags, enables, event log and the bus read path.
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] en_r, en_nxt;
  logic [7:0] log_r, log_nxt;
  logic [7:0] lmask_r, lmask_nxt;
  logic [7:0] rdata_nxt, req_nxt, w1c;
  logic irq_nxt;

  always_comb begin
    w1c = tim_pkg::RESET_BYTE;
    en_nxt = en_r;
    lmask_nxt = lmask_r;
    log_nxt = log_r;
    rdata_nxt = tim_pkg::RESET_BYTE;
    if (wr_i && addr_i == tim_pkg::ADDR_FLAGS) begin
      w1c = wdata_i & tim_pkg::IMPL_MASK;
    end
    if (wr_i && addr_i == tim_pkg::ADDR_ENABLES) begin
      en_nxt = wdata_i & tim_pkg::IMPL_MASK;
    end
    if (wr_i && addr_i == tim_pkg::ADDR_EVMASK) begin
      lmask_nxt = wdata_i & tim_pkg::IMPL_MASK;
    end
    flags_nxt = ((flags_r & ~w1c & ~vector_ack_i) | set_vec) & tim_pkg::IMPL_MASK;
    // A read of the log clears it, but an event in that cycle survives.
    if (rd_i && addr_i == tim_pkg::ADDR_EVLOG) begin
      log_nxt = tim_pkg::RESET_BYTE;
    end
    log_nxt = (log_nxt | set_vec) & tim_pkg::IMPL_MASK;
    irq_nxt = |(log_nxt & lmask_nxt);
    req_nxt = flags_nxt & en_nxt & {8{global_irq_enable_i}};
    if (rd_i) begin
      case (addr_i)
        tim_pkg::ADDR_FLAGS: rdata_nxt = flags_r;
        tim_pkg::ADDR_ENABLES: rdata_nxt = en_r;
        tim_pkg::ADDR_EVLOG: rdata_nxt = log_r;
        tim_pkg::ADDR_EVMASK: rdata_nxt = lmask_r;
        tim_pkg::ADDR_MODE: rdata_nxt = {4'h0, mode_r};
        tim_pkg::ADDR_CNT_L: rdata_nxt = cnt_r[7:0];
        tim_pkg::ADDR_CNT_H: rdata_nxt = cnt_r[15:8];
        tim_pkg::ADDR_CAP_L: rdata_nxt = cap_r[7:0];
        tim_pkg::ADDR_CAP_H: rdata_nxt = cap_r[15:8];
        tim_pkg::ADDR_CMPA_L: rdata_nxt = cmpa_r[7:0];
        tim_pkg::ADDR_CMPA_H: rdata_nxt = cmpa_r[15:8];
        tim_pkg::ADDR_CMPB_L: rdata_nxt = cmpb_r[7:0];
        tim_pkg::ADDR_CMPB_H: rdata_nxt = cmpb_r[15:8];
        tim_pkg::ADDR_CMPC_L: rdata_nxt = cmpc_r[7:0];
        tim_pkg::ADDR_CMPC_H: rdata_nxt = cmpc_r[15:8];
        default: rdata_nxt = tim_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_r <= tim_pkg::RESET_BYTE;
      en_r <= tim_pkg::RESET_BYTE;
      log_r <= tim_pkg::RESET_BYTE;
      lmask_r <= tim_pkg::RESET_BYTE;
      rdata_o <= tim_pkg::RESET_BYTE;
      irq_req_o <= tim_pkg::RESET_BYTE;
      irq_o <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      en_r <= en_nxt;
      log_r <= log_nxt;
      lmask_r <= lmask_nxt;
      rdata_o <= rdata_nxt;
      irq_req_o <= req_nxt;
      irq_o <= irq_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CAP_REQ: assert property (
    irq_req_o[tim_pkg::BIT_CAP] == (flags_r[tim_pkg::BIT_CAP] & en_r[tim_pkg::BIT_CAP] &
                                    $past(global_irq_enable_i)))
    else $error("capture request does not follow flag, enable and global enable");
  AST_CMPC_REQ: assert property (
    irq_req_o[tim_pkg::BIT_CMPC] |-> flags_r[tim_pkg::BIT_CMPC] && en_r[tim_pkg::BIT_CMPC])
    else $error("channel C request without flag and enable");
  AST_CMPB_REQ: assert property (
    !$past(global_irq_enable_i) |-> !irq_req_o[tim_pkg::BIT_CMPB])
    else $error("channel B request while globally disabled");
  AST_CMPA_REQ: assert property (
    irq_req_o[tim_pkg::BIT_CMPA] == (flags_r[tim_pkg::BIT_CMPA] & en_r[tim_pkg::BIT_CMPA] &
                                     $past(global_irq_enable_i)))
    else $error("channel A request does not follow its causes");
  AST_OVF_REQ: assert property (
    irq_req_o[tim_pkg::BIT_OVF] |-> flags_r[tim_pkg::BIT_OVF] && en_r[tim_pkg::BIT_OVF])
    else $error("overflow request without flag and enable");
  AST_RESERVED_ZERO: assert property (
    rd_i && (addr_i == tim_pkg::ADDR_FLAGS || addr_i == tim_pkg::ADDR_ENABLES)
    |=> (rdata_o & ~tim_pkg::IMPL_MASK) == tim_pkg::RESET_BYTE)
    else $error("reserved bit read as one");
  AST_PIN_CAPTURE: assert property (
    $rose(pin_s2_r) && !top_is_capture(mode_r) |=> flags_r[tim_pkg::BIT_CAP])
    else $error("capture pin edge did not set the capture flag");
  AST_CAP_LOAD: assert property (
    pin_rise && !top_is_capture(mode_r) |=> cap_r == $past(cnt_r))
    else $error("capture value not loaded from counter");
  AST_CMPA_SET: assert property (
    count_tick_i && cnt_r == cmpa_r |=> flags_r[tim_pkg::BIT_CMPA])
    else $error("channel A match flag not set one cycle after equality");
  AST_VECTOR_CLEAR: assert property (
    vector_ack_i[tim_pkg::BIT_CMPB] && !set_vec[tim_pkg::BIT_CMPB]
    |=> !flags_r[tim_pkg::BIT_CMPB])
    else $error("channel B flag survived its vector");
  AST_W1C: assert property (
    wr_i && addr_i == tim_pkg::ADDR_FLAGS && !wdata_i[tim_pkg::BIT_OVF] &&
    flags_r[tim_pkg::BIT_OVF] |=> flags_r[tim_pkg::BIT_OVF])
    else $error("writing zero cleared the overflow flag");
  AST_OVF_NORMAL: assert property (
    count_tick_i && mode_r == tim_pkg::MODE_NORMAL && cnt_r == tim_pkg::CNT_MAX
    |=> flags_r[tim_pkg::BIT_OVF] && cnt_r == tim_pkg::RESET_WORD)
    else $error("normal mode overflow did not set the flag and wrap");
  AST_CMPB_SET: assert property (
    count_tick_i && cnt_r == cmpb_r |=> flags_r[tim_pkg::BIT_CMPB])
    else $error("channel B match flag not set one cycle after equality");
  AST_CMPC_SET: assert property (
    count_tick_i && cnt_r == cmpc_r |=> flags_r[tim_pkg::BIT_CMPC])
    else $error("channel C match flag not set one cycle after equality");
  AST_CAP_TOP: assert property (
    count_tick_i && top_is_capture(mode_r) && cnt_r == cap_r |=> flags_r[tim_pkg::BIT_CAP])
    else $error("capture flag not set when the counter reached the capture top");
  AST_W1C_CLEAR: assert property (
    wr_i && addr_i == tim_pkg::ADDR_FLAGS && wdata_i[tim_pkg::BIT_CMPA] &&
    !set_vec[tim_pkg::BIT_CMPA] |=> !flags_r[tim_pkg::BIT_CMPA])
    else $error("writing one did not clear the channel A flag");

  COV_CAP_IRQ: cover property (irq_req_o[tim_pkg::BIT_CAP] ##1 vector_ack_i[tim_pkg::BIT_CAP]);
  COV_CMPA_IRQ: cover property (count_tick_i && cnt_r == cmpa_r ##2 irq_req_o[tim_pkg::BIT_CMPA]);
  COV_OVF_W1C: cover property (flags_r[tim_pkg::BIT_OVF] && wr_i && addr_i == tim_pkg::ADDR_FLAGS);
  COV_LOG_IRQ: cover property (irq_o ##1 rd_i && addr_i == tim_pkg::ADDR_EVLOG);
  COV_CAP_TOP: cover property (count_tick_i && top_is_capture(mode_r) && at_top);

endmodule // tim_irq_flags

// ### hdl/tim_pkg.sv
// Constants shared by the timer interrupt flag and enable block.
// Assumes an 8-bit register port with byte addresses as printed.
package tim_pkg;
  localparam logic [7:0] ADDR_FLAGS = 8'h38;
  localparam logic [7:0] ADDR_ENABLES = 8'h71;
  localparam logic [7:0] ADDR_EVLOG = 8'h3a;
  localparam logic [7:0] ADDR_EVMASK = 8'h3b;
  localparam logic [7:0] ADDR_MODE = 8'h90;
  localparam logic [7:0] ADDR_CNT_L = 8'h94;
  localparam logic [7:0] ADDR_CNT_H = 8'h95;
  localparam logic [7:0] ADDR_CAP_L = 8'h96;
  localparam logic [7:0] ADDR_CAP_H = 8'h97;
  localparam logic [7:0] ADDR_CMPA_L = 8'h98;
  localparam logic [7:0] ADDR_CMPA_H = 8'h99;
  localparam logic [7:0] ADDR_CMPB_L = 8'h9a;
  localparam logic [7:0] ADDR_CMPB_H = 8'h9b;
  localparam logic [7:0] ADDR_CMPC_L = 8'h9c;
  localparam logic [7:0] ADDR_CMPC_H = 8'h9d;
  localparam int BIT_OVF = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CMPC = 3;
  localparam int BIT_CAP = 5;
  localparam logic [7:0] IMPL_MASK = 8'h2f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'ha;
  localparam logic [3:0] MODE_PC_CMPA = 4'hb;
  localparam logic [3:0] MODE_CTC_CAP = 4'hc;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hf;
endpackage

// ### tb/tim_cpu_model.sv
// Processor core model: watches the interrupt requests and runs one vector at a time.
// Assumes the timer block's clock and a request that drops once its vector has run.
`timescale 1ns/100ps
module tim_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] irq_req_i,
  input wire logic ack_en_i,
  input wire logic [3:0] wait_i,
  output logic [7:0] vector_ack_o,
  output logic [7:0] ack_count_o
);
  logic [3:0] wait_r;
  // vector execution.
  // A wait below one cycle would run the same vector twice, as the request is registered.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_r <= 4'h0;
      vector_ack_o <= 8'h00;
      ack_count_o <= 8'h00;
    end else begin
      vector_ack_o <= 8'h00;
      if (!ack_en_i || irq_req_i == 8'h00) begin
        wait_r <= 4'h0;
      end else if (wait_r == wait_i) begin
        vector_ack_o <= irq_req_i & (~irq_req_i + 8'h01);
        ack_count_o <= ack_count_o + 8'h01;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule // tim_cpu_model

// ### tb/tim_irq_flags_tb_top.sv
// Self-checking bench for the timer flag and enable block.
// Assumes the processor model drives the vector inputs and the bench owns the register port.
`timescale 1ns/100ps
module tim_irq_flags_tb_top;
  typedef struct {logic [7:0] oa; logic [7:0] ob; logic [7:0] oc; logic [7:0] n;
    logic [7:0] en; logic g;} tim_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic gie = 1'b0;
  logic tick = 1'b0;
  logic pin = 1'b0;
  logic ack_en = 1'b0;
  logic [7:0] vack;
  logic [7:0] rdata;
  logic [7:0] req;
  logic irq;
  logic [7:0] acks;
  logic [7:0] exp;
  logic [15:0] cnt = 16'h0000;
  int miscompares = 0;
  int compares = 0;
  tim_row_t rows [4] = '{'{8'h00, 8'h01, 8'h02, 8'h02, 8'h0e, 1'b1},
    '{8'h03, 8'h02, 8'h09, 8'h04, 8'h02, 1'b1}, '{8'h01, 8'h05, 8'h00, 8'h02, 8'h0e, 1'b0},
    '{8'h07, 8'h07, 8'h07, 8'h08, 8'h0c, 1'b1}};

  tim_irq_flags tim_irq_flags_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .global_irq_enable_i(gie),
    .vector_ack_i(vack), .count_tick_i(tick), .capture_input_pin_i(pin),
    .rdata_o(rdata), .irq_req_o(req), .irq_o(irq));
  tim_cpu_model tim_cpu_model_inst (.clk_i(clk_i), .rst_i(rst_i), .irq_req_i(req),
    .ack_en_i(ack_en), .wait_i(4'h3), .vector_ack_o(vack), .ack_count_o(acks));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    compares++;
    if (got !== want) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] want);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk8(rdata & m, want);
  endtask

  task automatic ticks(input int n);
    @(posedge clk_i);
    tick <= 1'b1;
    repeat (n) @(posedge clk_i);
    tick <= 1'b0;
    cnt = cnt + n[15:0];
  endtask

  // The longest path is one full counter wrap plus a few hundred bus cycles.
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(tim_pkg::ADDR_FLAGS, 8'hff, 8'h00);
    rd(tim_pkg::ADDR_ENABLES, 8'hff, 8'h00);
    chk8(req, 8'h00);
    wr(tim_pkg::ADDR_ENABLES, 8'hff);
    rd(tim_pkg::ADDR_ENABLES, 8'hff, tim_pkg::IMPL_MASK);
    wr(tim_pkg::ADDR_FLAGS, 8'hd0);
    rd(tim_pkg::ADDR_FLAGS, 8'hff, 8'h00);
    rd(8'h50, 8'hff, 8'h00);
    foreach (rows[i]) begin
      wr16(tim_pkg::ADDR_CMPA_L, cnt + {8'h00, rows[i].oa});
      wr16(tim_pkg::ADDR_CMPB_L, cnt + {8'h00, rows[i].ob});
      wr16(tim_pkg::ADDR_CMPC_L, cnt + {8'h00, rows[i].oc});
      wr(tim_pkg::ADDR_ENABLES, rows[i].en);
      gie <= rows[i].g;
      wr(tim_pkg::ADDR_FLAGS, 8'h2f);
      ticks(int'(rows[i].n));
      exp = {4'h0, rows[i].oc < rows[i].n, rows[i].ob < rows[i].n, rows[i].oa < rows[i].n, 1'b0};
      rd(tim_pkg::ADDR_FLAGS, 8'hff, exp);
      chk8(req, exp & rows[i].en & {8{rows[i].g}});
    end
    wr16(tim_pkg::ADDR_CMPA_L, cnt + 16'h0001);
    wr(tim_pkg::ADDR_ENABLES, 8'h02);
    wr(tim_pkg::ADDR_FLAGS, 8'h2f);
    ack_en <= 1'b1;
    ticks(2);
    repeat (12) @(posedge clk_i);
    rd(tim_pkg::ADDR_FLAGS, 8'h02, 8'h00);
    chk8(acks, 8'h01);
    ack_en <= 1'b0;
    rd(tim_pkg::ADDR_EVLOG, 8'hff, 8'h0e);
    wr(tim_pkg::ADDR_EVMASK, 8'h01);
    wr(tim_pkg::ADDR_FLAGS, 8'h2f);
    wr(tim_pkg::ADDR_ENABLES, 8'h01);
    ticks(65536 - int'(cnt));
    rd(tim_pkg::ADDR_FLAGS, 8'h01, 8'h01);
    chk8(req & 8'h01, 8'h01);
    chk8({7'h00, irq}, 8'h01);
    wr(tim_pkg::ADDR_EVMASK, 8'h00);
    repeat (2) @(negedge clk_i);
    chk8({7'h00, irq}, 8'h00);
    wr(tim_pkg::ADDR_EVMASK, 8'h01);
    rd(tim_pkg::ADDR_EVLOG, 8'h01, 8'h01);
    repeat (2) @(negedge clk_i);
    chk8({7'h00, irq}, 8'h00);
    wr(tim_pkg::ADDR_FLAGS, 8'h2f);
    wr(tim_pkg::ADDR_ENABLES, 8'h20);
    ticks(4);
    @(posedge clk_i);
    pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(tim_pkg::ADDR_FLAGS, 8'h20, 8'h20);
    chk8(req & 8'h20, 8'h20);
    rd(tim_pkg::ADDR_CAP_L, 8'hff, cnt[7:0]);
    wr(tim_pkg::ADDR_FLAGS, 8'h00);
    rd(tim_pkg::ADDR_FLAGS, 8'h20, 8'h20);
    wr(tim_pkg::ADDR_FLAGS, 8'h20);
    rd(tim_pkg::ADDR_FLAGS, 8'h20, 8'h00);
    wr(tim_pkg::ADDR_MODE, {4'h0, tim_pkg::MODE_CTC_CAP});
    ticks(6);
    rd(tim_pkg::ADDR_FLAGS, 8'h20, 8'h20);
    wr(tim_pkg::ADDR_ENABLES, 8'h2f);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(tim_pkg::ADDR_ENABLES, 8'hff, 8'h00);
    rd(tim_pkg::ADDR_FLAGS, 8'hff, 8'h00);
    chk8(req, 8'h00);
    give_verdict();
  end
endmodule // tim_irq_flags_tb_top
